//--- pwrirq_pkg.sv
// Package: register map, fields, resets and timing of the power event block
package pwrirq_pkg;

    // Register addresses on the core's special register space
    localparam logic [7:0] ADDR_IRQ_EN_PRIO2  = 8'hA9;
    localparam logic [7:0] ADDR_EVENT_ENABLE  = 8'hEC;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIGURATION_CFG    = 8'hF4;
    localparam logic [7:0] ADDR_SWITCH_CFG    = 8'hF5;
    localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'hF8;
    localparam logic [7:0] ADDR_CONV_START    = 8'hD8;
    localparam logic [7:0] ADDR_BATT_VALUE    = 8'hDF;

    // Bit positions shared by the flag and enable registers
    localparam int BIT_SWITCHOVER  = 0;
    localparam int BIT_RESTORE     = 1;
    localparam int BIT_MEAS_CHANGE = 2;
    localparam int BIT_BATTERY     = 3;
    localparam int BIT_INPUT_LOW   = 4;
    localparam int BIT_SAG         = 5;
    localparam int BIT_MEAS_READY  = 6;
    localparam int NUM_EVENTS      = 7;

    // Master enable inside the second interrupt enable register
    localparam int BIT_MASTER_EN   = 1;
    // Rail source status inside the peripheral configuration register
    localparam int BIT_RAIL_SOURCE = 6;

    // Reset values
    localparam logic [7:0] RST_IRQ_EN_PRIO2 = 8'h00;
    localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS  = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_CONFIGURATION_CFG   = 8'h00;
    localparam logic [7:0] RST_SWITCH_CFG   = 8'h00;

    // Switchover configuration field values
    localparam logic [1:0] CFG_MAIN_ONLY    = 2'h0;
    localparam logic [1:0] CFG_INPUT_LOW    = 2'h1;

    // Switchover and restore delays
    localparam int  CLK_MHZ       = 200;
    localparam int  T_SWITCH_MS   = 30;
    localparam int  T_RESTORE_MS  = 130;
    localparam longint SWITCH_CYC = longint'(T_SWITCH_MS) * 1000 * CLK_MHZ;
    localparam longint RESTORE_CYC = longint'(T_RESTORE_MS) * 1000 * CLK_MHZ;

endpackage // pwrirq_pkg

//--- pwrirq_delay.sv
// Delay timer: qualifies a level that must hold for a programmed time
`timescale 1ns/1ps
module pwrirq_delay #(
    parameter int CYCLES = 6000000,
    parameter int WIDTH  = 24
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Condition and result
    input  wire logic i_cond,
    output logic      o_done
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             done;
    } pwrirq_dly_t;

    pwrirq_dly_t st_q;
    pwrirq_dly_t st_d;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(CYCLES - 1);

    always_comb
    begin
        st_d = st_q;
        // Any drop of the condition restarts the wait
        if (!i_cond)
        begin
            st_d.cnt  = '0;
            st_d.done = 1'b0;
        end
        else if (st_q.cnt == LAST)
            st_d.done = 1'b1;
        else
            st_d.cnt = st_q.cnt + 1'b1;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_done = st_q.done;

endmodule // pwrirq_delay

//--- pwrirq_top.sv
// Power supply event interrupt block with rail switchover control
`timescale 1ns/1ps
module pwrirq_top #(
    parameter int SWITCH_CYCLES  = int'(pwrirq_pkg::SWITCH_CYC),
    parameter int RESTORE_CYCLES = int'(pwrirq_pkg::RESTORE_CYC),
    parameter int TIMER_WIDTH    = 25
) (
    // Clock and reset
    input  wire logic       I_MCLK,
    input  wire logic       I_RESET,
    // Special register port from the core
    input  wire logic [7:0] I_REG_ADDR,
    input  wire logic [7:0] I_REG_WDATA,
    input  wire logic       I_REG_WR,
    input  wire logic       I_REG_RD,
    output logic      [7:0] O_REG_RDATA,
    // Analog and measurement event inputs (asynchronous)
    input  wire logic       I_MAIN_LOW,
    input  wire logic       I_INPUT_LOW,
    input  wire logic       I_MEAS_CHANGE,
    input  wire logic       I_MEAS_READY,
    input  wire logic       I_BATT_LOW,
    input  wire logic       I_BATT_RESULT,
    input  wire logic       I_SAG,
    // Outputs
    output logic            O_IRQ,
    output logic            O_CONV_START,
    output logic            O_RAIL_ON_BATTERY
);

    localparam int NE = pwrirq_pkg::NUM_EVENTS;
    localparam int NS = 7;

    typedef enum logic [0:0] {
        PWRIRQ_MAIN    = 1'b0,
        PWRIRQ_BATTERY = 1'b1
    } pwrirq_rail_t;

    typedef struct packed {
        logic [NS-1:0] sync1;
        logic [NS-1:0] sync2;
        logic [NS-1:0] prev;
        logic [7:0]    ie2;
        logic [7:0]    en;
        logic [7:0]    flags;
        logic [1:0]    swcfg;
        logic          swdis;
        pwrirq_rail_t  rail;
        logic          rail_prev;
        logic [7:0]    rdata;
        logic          irq;
        logic          conv;
    } pwrirq_state_t;

    pwrirq_state_t st_q;
    pwrirq_state_t st_d;

    logic switch_done;
    logic restore_done;
    logic input_low_s;
    logic main_low_s;
    logic restore_ok;

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = I_REG_WR && (I_REG_ADDR == a);
    endfunction

    assign main_low_s  = st_q.sync2[0];
    assign input_low_s = st_q.sync2[1];

    // Restore needs main good, plus input good when input-low mode is on
    assign restore_ok = !main_low_s &&
        !((st_q.swcfg == pwrirq_pkg::CFG_INPUT_LOW) && input_low_s);

    // Switchover on low input waits the typical qualification time
    pwrirq_delay #(
        .CYCLES (SWITCH_CYCLES),
        .WIDTH  (TIMER_WIDTH)
    ) u_switch_dly (
        .i_clk   (I_MCLK),
        .i_reset (I_RESET),
        .i_cond  (input_low_s &&
                  (st_q.swcfg == pwrirq_pkg::CFG_INPUT_LOW)),
        .o_done  (switch_done)
    );

    pwrirq_delay #(
        .CYCLES (RESTORE_CYCLES),
        .WIDTH  (TIMER_WIDTH)
    ) u_restore_dly (
        .i_clk   (I_MCLK),
        .i_reset (I_RESET),
        .i_cond  (restore_ok && st_q.rail == PWRIRQ_BATTERY),
        .o_done  (restore_done)
    );

    always_comb
    begin
        logic [NS-1:0] raw;
        logic [NS-1:0] rise;
        logic [7:0]    set;
        set  = 8'h00;
        raw  = {I_SAG, I_BATT_RESULT, I_BATT_LOW, I_MEAS_READY,
                I_MEAS_CHANGE, I_INPUT_LOW, I_MAIN_LOW};
        // Only rising edges count, so a lasting condition sets once
        rise = st_q.sync2 & ~st_q.prev;
        st_d = st_q;
        st_d.sync1 = raw;
        st_d.sync2 = st_q.sync1;
        st_d.prev  = st_q.sync2;

        // Rail source selection
        st_d.rail_prev = st_q.rail;
        if (st_q.rail == PWRIRQ_MAIN && !st_q.swdis)
        begin
            if ((st_q.swcfg == pwrirq_pkg::CFG_MAIN_ONLY && main_low_s)
                || (st_q.swcfg == pwrirq_pkg::CFG_INPUT_LOW &&
                    (main_low_s || switch_done)))
                st_d.rail = PWRIRQ_BATTERY;
        end
        else if (st_q.rail == PWRIRQ_BATTERY &&
                 (restore_done || st_q.swdis))
            st_d.rail = PWRIRQ_MAIN;

        // Flag sources; set whatever the enables hold
        set[pwrirq_pkg::BIT_SWITCHOVER] = st_q.rail == PWRIRQ_BATTERY &&
            st_q.rail_prev == PWRIRQ_MAIN;
        set[pwrirq_pkg::BIT_RESTORE] = st_q.rail == PWRIRQ_MAIN &&
            st_q.rail_prev == PWRIRQ_BATTERY;
        set[pwrirq_pkg::BIT_INPUT_LOW]   = rise[1];
        set[pwrirq_pkg::BIT_MEAS_CHANGE] = rise[2];
        set[pwrirq_pkg::BIT_MEAS_READY]  = rise[3];
        set[pwrirq_pkg::BIT_BATTERY]     = rise[4] || rise[5]
            || wr_hit(pwrirq_pkg::ADDR_BATT_VALUE);
        set[pwrirq_pkg::BIT_SAG]         = rise[6];

        // Register writes
        if (wr_hit(pwrirq_pkg::ADDR_IRQ_EN_PRIO2))
            st_d.ie2 = I_REG_WDATA;
        if (wr_hit(pwrirq_pkg::ADDR_EVENT_ENABLE))
            st_d.en = I_REG_WDATA;
        if (wr_hit(pwrirq_pkg::ADDR_SWITCH_CFG))
        begin
            st_d.swcfg = I_REG_WDATA[1:0];
            st_d.swdis = I_REG_WDATA[1];
        end
        // Software only clears: written zeros drop flags, ones are ignored
        if (wr_hit(pwrirq_pkg::ADDR_EVENT_FLAGS))
            st_d.flags = st_q.flags & I_REG_WDATA;
        // Set wins over a clear in the same cycle
        st_d.flags = st_d.flags | set;
        st_d.flags[7] = 1'b0;

        // Conversion start pulse on a write to the start register
        st_d.conv = wr_hit(pwrirq_pkg::ADDR_CONV_START);

        // Shared request
        st_d.irq = st_q.ie2[pwrirq_pkg::BIT_MASTER_EN] &&
            |(st_q.flags[NE-1:0] & st_q.en[NE-1:0]);

        // Read data
        st_d.rdata = 8'h00;
        if (I_REG_RD)
        begin
            case (I_REG_ADDR)
                pwrirq_pkg::ADDR_IRQ_EN_PRIO2: st_d.rdata = st_q.ie2;
                pwrirq_pkg::ADDR_EVENT_ENABLE: st_d.rdata = st_q.en;
                pwrirq_pkg::ADDR_EVENT_FLAGS:  st_d.rdata = st_q.flags;
                pwrirq_pkg::ADDR_SWITCH_CFG:
                    st_d.rdata = {6'h00, st_q.swcfg};
                pwrirq_pkg::ADDR_PERIPHERAL_CONFIGURATION_CFG:
                    st_d.rdata[pwrirq_pkg::BIT_RAIL_SOURCE] =
                        (st_q.rail == PWRIRQ_MAIN);
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            st_q           <= '0;
            st_q.ie2       <= pwrirq_pkg::RST_IRQ_EN_PRIO2;
            st_q.en        <= pwrirq_pkg::RST_EVENT_ENABLE;
            st_q.flags     <= pwrirq_pkg::RST_EVENT_FLAGS;
            st_q.swcfg     <= pwrirq_pkg::RST_SWITCH_CFG[1:0];
            st_q.swdis     <= pwrirq_pkg::RST_SWITCH_CFG[1];
            st_q.rail      <= PWRIRQ_MAIN;
            st_q.rail_prev <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    assign O_REG_RDATA       = st_q.rdata;
    assign O_IRQ             = st_q.irq;
    assign O_CONV_START      = st_q.conv;
    assign O_RAIL_ON_BATTERY = st_q.rail;

endmodule // pwrirq_top

//--- pwrirq_monitor.sv
// Port checker of the power event interrupt block
`timescale 1ns/1ps
module pwrirq_monitor #(
    parameter int SWITCH_CYCLES  = 20,
    parameter int RESTORE_CYCLES = 40
) (
    // Watched ports
    input wire logic       I_MCLK,
    input wire logic       I_RESET,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic       I_REG_WR,
    input wire logic       I_REG_RD,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic       I_MAIN_LOW,
    input wire logic       O_IRQ,
    input wire logic       O_CONV_START,
    input wire logic       O_RAIL_ON_BATTERY
);
    logic mst_q;
    logic off_q;
    logic unm;
    logic cvw;
    // Shadow of the master enable and switchover disable bits
    always_ff @(posedge I_MCLK or posedge I_RESET)
        if (I_RESET)
        begin
            mst_q <= 1'b0;
            off_q <= 1'b0;
        end
        else if (I_REG_WR)
        begin
            if (I_REG_ADDR == 8'hA9)
                mst_q <= I_REG_WDATA[1];
            if (I_REG_ADDR == 8'hF5)
                off_q <= I_REG_WDATA[1];
        end
    assign unm = !(I_REG_ADDR inside {8'hA9, 8'hEC, 8'hF4, 8'hF5, 8'hF8,
                                      8'hD8, 8'hDF});
    assign cvw = I_REG_WR && I_REG_ADDR == 8'hD8;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    irq_reset_a: assert property ($fell(I_RESET) |-> !O_IRQ)
        else $error("request right after reset");
    master_gate_a: assert property (O_IRQ |-> mst_q || $past(mst_q))
        else $error("request without master enable");
    rdata_idle_a: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 8'h00)
        else $error("read data without read");
    unmapped_read_a: assert property ($past(I_REG_RD && unm) |->
        O_REG_RDATA == 8'h00) else $error("unmapped read not zero");
    conv_pulse_a: assert property (cvw |=> O_CONV_START)
        else $error("no conversion pulse");
    conv_cause_a: assert property (O_CONV_START |-> $past(cvw))
        else $error("stray conversion pulse");
    rail_status_a: assert property ($past(I_REG_RD && I_REG_ADDR == 8'hF4)
        |-> O_REG_RDATA[6] == !$past(O_RAIL_ON_BATTERY))
        else $error("rail status bit wrong");
    rail_switch_a: assert property ((I_MAIN_LOW && !off_q) [*6]
        |-> O_RAIL_ON_BATTERY) else $error("rail did not switch");
endmodule // pwrirq_monitor
bind pwrirq_top pwrirq_monitor #(.SWITCH_CYCLES(SWITCH_CYCLES),
    .RESTORE_CYCLES(RESTORE_CYCLES)) i_mon (.I_MCLK, .I_RESET, .I_REG_ADDR,
    .I_REG_WDATA, .I_REG_WR, .I_REG_RD, .O_REG_RDATA, .I_MAIN_LOW, .O_IRQ,
    .O_CONV_START, .O_RAIL_ON_BATTERY);

//--- pwrirq_core_model.sv
// Core-side model that takes the shared request
`timescale 1ns/1ps
module pwrirq_core_model (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Request in, vectors taken out
    input  wire logic i_irq,
    output int        o_taken
);
    logic irq_q;
    // A level held high is one vector fetch, not one per cycle
    always_ff @(posedge i_clk or posedge i_reset)
        if (i_reset)
        begin
            irq_q   <= 1'b0;
            o_taken <= 0;
        end
        else
        begin
            irq_q <= i_irq;
            if (i_irq && !irq_q)
                o_taken <= o_taken + 1;
        end
endmodule // pwrirq_core_model

//--- test_power_event_interrupt.sv
// Self-checking bench of the power event interrupt block
`timescale 1ns/1ps
module test_power_event_interrupt;
    localparam int SW = 20;
    localparam int RS = 40;
    // Event input pattern beside the flags it must latch
    localparam logic [13:0] ROW [6] = '{{6'h01, 8'h04}, {6'h02, 8'h08},
        {6'h04, 8'h08}, {6'h08, 8'h10}, {6'h10, 8'h20}, {6'h20, 8'h40}};
    logic       clk  = 1'b0;
    logic       rst  = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic       wr   = 1'b0;
    logic       rd   = 1'b0;
    logic       mlow = 1'b0;
    logic [5:0] ev   = 6'h00;
    logic [7:0] rdat;
    logic       irq;
    logic       conv;
    logic       bat;
    int         taken;
    int         n_fail      = 0;
    int         comparisons = 0;
    initial forever #2.5 clk = ~clk;
    pwrirq_top #(.SWITCH_CYCLES(SW), .RESTORE_CYCLES(RS)) i_dut (
        .I_MCLK(clk), .I_RESET(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdat),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdat),
        .I_MAIN_LOW(mlow), .I_INPUT_LOW(ev[3]), .I_MEAS_CHANGE(ev[0]),
        .I_MEAS_READY(ev[5]), .I_BATT_LOW(ev[1]), .I_BATT_RESULT(ev[2]),
        .I_SAG(ev[4]), .O_IRQ(irq), .O_CONV_START(conv),
        .O_RAIL_ON_BATTERY(bat));
    pwrirq_core_model i_core (.i_clk(clk), .i_reset(rst), .i_irq(irq),
        .o_taken(taken));
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] a, d);
        @(negedge clk);
        addr = a;
        wdat = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, exp, input string nm);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(nm, rdat, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        idle(12);
        rst = 1'b0;
        chk("irq", {7'h00, irq}, 8'h00);
        rchk(8'hA9, 8'h00, "master");
        rchk(8'hEC, 8'h00, "enables");
        rchk(8'hF8, 8'h00, "flags");
        rchk(8'hF4, 8'h40, "status");
        wreg(8'hA0, 8'hFF);
        rchk(8'hA0, 8'h00, "unmapped");
        wreg(8'hA9, 8'h02);
        for (int i = 0; i < 6; i++)
        begin
            wreg(8'hEC, 8'h00);
            ev = ROW[i][13:8];
            idle(6);
            chk("irq", {7'h00, irq}, 8'h00);
            rchk(8'hF8, ROW[i][7:0], "flags");
            wreg(8'hEC, ROW[i][7:0]);
            idle(3);
            chk("irq", {7'h00, irq}, 8'h01);
            wreg(8'hA9, 8'h00);
            idle(3);
            chk("irq", {7'h00, irq}, 8'h00);
            wreg(8'hF8, ~ROW[i][7:0]);
            wreg(8'hA9, 8'h02);
            idle(6);
            chk("irq", {7'h00, irq}, 8'h00);
            rchk(8'hF8, 8'h00, "flags");
            ev = 6'h00;
        end
        chk("taken", taken[7:0], 8'h06);
        wreg(8'hD8, 8'h01);
        chk("conv", {7'h00, conv}, 8'h01);
        wreg(8'hDF, 8'h55);
        rchk(8'hF8, 8'h08, "flags");
        wreg(8'hF8, 8'hF7);
        mlow = 1'b1;
        idle(8);
        chk("rail", {7'h00, bat}, 8'h01);
        rchk(8'hF4, 8'h00, "status");
        rchk(8'hF8, 8'h01, "flags");
        wreg(8'hF8, 8'hFE);
        rchk(8'hF8, 8'h00, "flags");
        mlow = 1'b0;
        idle(RS - 8);
        chk("rail", {7'h00, bat}, 8'h01);
        idle(18);
        chk("rail", {7'h00, bat}, 8'h00);
        rchk(8'hF8, 8'h02, "flags");
        wreg(8'hF5, 8'h01);
        ev[3] = 1'b1;
        idle(SW - 8);
        chk("rail", {7'h00, bat}, 8'h00);
        idle(16);
        chk("rail", {7'h00, bat}, 8'h01);
        ev[3] = 1'b0;
        idle(RS + 10);
        chk("rail", {7'h00, bat}, 8'h00);
        wreg(8'hF5, 8'h02);
        mlow = 1'b1;
        idle(8);
        chk("rail", {7'h00, bat}, 8'h00);
        rchk(8'hF5, 8'h02, "swcfg");
        mlow = 1'b0;
        wreg(8'hEC, 8'hFF);
        idle(3);
        chk("irq", {7'h00, irq}, 8'h01);
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        idle(2);
        chk("irq", {7'h00, irq}, 8'h00);
        rchk(8'hF8, 8'h00, "flags");
        results();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #20000;
        n_fail++;
        results();
    end
endmodule // test_power_event_interrupt
